// ==== core/clk_select_pkg.sv ====
// Constants, field layouts, reset values and types of the clock source
// selection block. Assumes an APB bus with 32-bit data and 8-bit address.
package clk_select_pkg;

  // ==========================================================
  // Sizes and indices
  localparam int NUM_PLL = 7;
  localparam int NUM_REFSEL = 6;
  localparam int N_SYNC = 14;
  localparam int NUM_DIV = 5;
  localparam int PLL_BIG0 = 0;
  localparam int PLL_BIG1 = 1;
  localparam int PLL_LITTLE0 = 2;
  localparam int PLL_LITTLE1 = 3;
  localparam int PLL_PIXEL = 4;
  localparam int PLL_MEMORY = 5;
  localparam int PLL_SYSTEM = 6;

  // ==========================================================
  // Register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIVIDE = 8'h08;
  localparam logic [7:0] OFS_PLL_BASE = 8'h10;
  localparam logic [7:0] OFS_PLL_LAST = 8'h44;
  localparam logic [7:0] OFS_GEN_REQ = 8'h48;
  localparam logic [7:0] OFS_GEN_ACT = 8'h4c;

  // ==========================================================
  // Field positions
  localparam int SEL_BIG_LSB = 0;
  localparam int SEL_LITTLE_LSB = 2;
  localparam int SEL_REF_LSB = 4;
  localparam int SEL_BYP_LSB = 10;
  localparam int SEL_INV_BIT = 17;
  localparam int STS_BIG_LSB = 0;
  localparam int STS_LITTLE_LSB = 2;
  localparam int STS_BIG_BUSY = 4;
  localparam int STS_LITTLE_BUSY = 5;
  localparam int DIV_DEBUG_LSB = 0;
  localparam int DIV_TRACE_LSB = 4;
  localparam int DIV_FABRIC_LSB = 8;
  localparam int OUT_DIV_LSB = 8;

  // ==========================================================
  // Widths and reset values
  localparam int DIV_W = 4;
  localparam int IN_DIV_W = 6;
  localparam int FB_DIV_W = 13;
  localparam int OUT_DIV_W = 4;
  localparam int GEN_W = 20;
  localparam logic [1:0] RST_CLUSTER_SEL = 2'h0;
  localparam logic [NUM_REFSEL-1:0] RST_REF_SEL = 6'h00;
  localparam logic [NUM_PLL-1:0] RST_BYPASS = 7'h10;
  localparam logic RST_INVERT = 1'b0;
  localparam logic [DIV_W-1:0] RST_DEBUG_DIV = 4'h2;
  localparam logic [DIV_W-1:0] RST_TRACE_DIV = 4'h4;
  localparam logic [DIV_W-1:0] RST_FABRIC_DIV = 4'h2;
  localparam logic [DIV_W-1:0] HALF_DIV = 4'h2;
  localparam logic [IN_DIV_W-1:0] RST_IN_DIV = 6'h00;
  localparam logic [OUT_DIV_W-1:0] RST_OUT_DIV = 4'h0;
  localparam logic [FB_DIV_W-1:0] RST_FB_X20 = 13'h0013;
  localparam logic [FB_DIV_W-1:0] RST_FB_X8 = 13'h0007;
  localparam logic [GEN_W-1:0] RST_GEN_REQ = 20'h0c350;
  localparam logic [GEN_W-1:0] RST_GEN_ACT = 20'h0c340;
  localparam logic [GEN_W-1:0] GEN_STEP_MASK = 20'h0003f;
  localparam logic [GEN_W:0] GEN_HALF_STEP = 21'h000020;

  // ==========================================================
  // Types
  typedef struct packed {
    logic bypass;
    logic ref_sel;
    logic [IN_DIV_W-1:0] in_div;
    logic [FB_DIV_W-1:0] fb_div;
    logic [OUT_DIV_W-1:0] out_div;
  } pll_cfg_s;

  typedef enum logic [1:0] {
    MUX_RUN = 2'b00,
    MUX_DRAIN = 2'b01,
    MUX_LOW = 2'b11,
    MUX_HIGH = 2'b10
  } mux_state_e;

  // Nearest achievable generator setting, saturating at the top step
  function automatic logic [GEN_W-1:0] round_to_step(
    input logic [GEN_W-1:0] req);
    logic [GEN_W:0] sum;
    sum = {1'b0, req} + GEN_HALF_STEP;
    if (sum[GEN_W]) begin
      round_to_step = ~GEN_STEP_MASK;
    end else begin
      round_to_step = sum[GEN_W-1:0] & ~GEN_STEP_MASK;
    end
  endfunction : round_to_step

endpackage : clk_select_pkg

// ==== core/clk_glitch_mux.sv ====
// Four-way glitch-free selector for one cluster clock.
// Assumes candidate levels already synchronised to pclk.
`timescale 1ns/1ns
module clk_glitch_mux
  import clk_select_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Candidates and request
  input wire logic [3:0] cand,
  input wire logic [1:0] sel,
  // Output and status
  output logic clk_out,
  output logic [1:0] active_sel,
  output logic busy
);

  mux_state_e state_reg, state_next;
  logic [1:0] cur_reg, cur_next;
  logic [1:0] act_reg, act_next;
  logic out_reg, out_next;

  // ==========================================================
  // Switch sequence: drain old low, hold low, wait new rising
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    act_next = act_reg;
    out_next = out_reg;
    case (state_reg)
      MUX_RUN: begin
        out_next = cand[cur_reg];
        if (sel != cur_reg) begin
          state_next = MUX_DRAIN;
        end
      end
      MUX_DRAIN: begin
        out_next = cand[cur_reg];
        if (!cand[cur_reg]) begin
          out_next = 1'b0;
          cur_next = sel;
          state_next = MUX_LOW;
        end
      end
      MUX_LOW: begin
        out_next = 1'b0;
        if (!cand[cur_reg]) begin
          state_next = MUX_HIGH;
        end
      end
      MUX_HIGH: begin
        out_next = 1'b0;
        if (cand[cur_reg]) begin
          out_next = 1'b1;
          act_next = cur_reg;
          state_next = MUX_RUN;
        end
      end
      default: begin
        state_next = MUX_RUN;
        out_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MUX_RUN;
      cur_reg <= RST_CLUSTER_SEL;
      act_reg <= RST_CLUSTER_SEL;
      out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      act_reg <= act_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;
  assign active_sel = act_reg;
  assign busy = (state_reg != MUX_RUN) || (sel != act_reg);

endmodule : clk_glitch_mux

// ==== core/clk_divider.sv ====
// Programmable divider clocked by the rising edges of a source level.
// Assumes the source is synchronised to pclk.
`timescale 1ns/1ns
module clk_divider
  import clk_select_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Source and ratio
  input wire logic src,
  input wire logic [DIV_W-1:0] ratio,
  // Divided output
  output logic clk_out
);

  logic src_d_reg, src_d_next;
  logic [DIV_W-1:0] cnt_reg, cnt_next;
  logic [DIV_W-1:0] ratio_reg, ratio_next;
  logic out_reg, out_next;
  logic rise;

  // ==========================================================
  // Count source edges; when dividing, new ratio only at wrap, so no runt
  always_comb begin
    rise = src & ~src_d_reg;
    src_d_next = src;
    cnt_next = cnt_reg;
    ratio_next = ratio_reg;
    out_next = out_reg;
    if (ratio_reg <= 4'h1) begin
      out_next = src;
      ratio_next = ratio;
    end else if (rise) begin
      if (cnt_reg >= ratio_reg - 4'h1) begin
        cnt_next = '0;
        ratio_next = ratio;
        out_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 4'h1;
        out_next = (cnt_reg + 4'h1) < (ratio_reg >> 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_reg <= 1'b0;
      cnt_reg <= '0;
      ratio_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      src_d_reg <= src_d_next;
      cnt_reg <= cnt_next;
      ratio_reg <= ratio_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;

endmodule : clk_divider

// ==== core/clock_source_select.sv ====
// Clock source selection, PLL configuration and derived clocks.
// Assumes APB master on pclk; clock pins arrive asynchronous to pclk.
// How it works
// - Each of six PLLs may take the system reference instead.
// - Cluster selectors reset to their own PLL0 outputs.
// - Each cluster clock has a glitch-free four-way selector.
// - Status register shows when a new cluster selection is live.
// - Board pixel clock is pixel reference, in phase or inverted.
// - Bypass feeds a PLL's reference straight in place of output.
// - Dividers default to 2 debug, 4 trace, 2 fabric.
// - Debug, trace and fabric clocks are stepped only by system PLL clock edges.
// - PLL defaults multiply by 20, memory PLL by 8.
// - Memory clock stays asynchronous to the fabric clock.
// - Generator setting rounds to nearest achievable step.
// - Each PLL has 6, 13 and 4 bit divider words in two registers.
// - Each cluster PLL0 also gives a divide-by-two output.
`timescale 1ns/1ns
module clock_source_select
  import clk_select_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PLL outputs
  input wire logic big_pll0_output,
  input wire logic big_pll1_output,
  input wire logic little_pll0_output,
  input wire logic little_pll1_output,
  input wire logic pixel_pll_output,
  input wire logic memory_pll_output,
  input wire logic system_pll_output,
  // Reference clocks
  input wire logic big_pll0_reference,
  input wire logic big_pll1_reference,
  input wire logic little_pll0_reference,
  input wire logic little_pll1_reference,
  input wire logic pixel_reference_clock,
  input wire logic memory_pll_reference,
  input wire logic system_reference_clock,
  // PLL control
  output pll_cfg_s [NUM_PLL-1:0] pll_cfg,
  output logic [NUM_PLL-1:0] pll_reference,
  output logic [GEN_W-1:0] generator_setting,
  // Derived clocks
  output logic big_cluster_clock,
  output logic little_cluster_clock,
  output logic board_pixel_clock_out,
  output logic pixel_clock,
  output logic memory_clock,
  output logic debug_clock,
  output logic trace_port_clock,
  output logic fabric_clock,
  output logic big_pll0_half,
  output logic little_pll0_half
);

  // ==========================================================
  // Pin synchronisers: change counts once stages two and three agree
  logic [N_SYNC-1:0] raw;
  logic [N_SYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
  logic [N_SYNC-1:0] s1_next, s2_next, s3_next, clean_next;

  assign raw = {system_reference_clock, memory_pll_reference,
                pixel_reference_clock, little_pll1_reference,
                little_pll0_reference, big_pll1_reference,
                big_pll0_reference, system_pll_output, memory_pll_output,
                pixel_pll_output, little_pll1_output, little_pll0_output,
                big_pll1_output, big_pll0_output};

  always_comb begin
    s1_next = raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
    clean_next = (~(s2_reg ^ s3_reg) & s3_reg) |
                 ((s2_reg ^ s3_reg) & clean_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      clean_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      clean_reg <= clean_next;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [1:0] big_sel_reg, big_sel_next;
  logic [1:0] little_sel_reg, little_sel_next;
  logic [NUM_REFSEL-1:0] ref_sel_reg, ref_sel_next;
  logic [NUM_PLL-1:0] bypass_reg, bypass_next;
  logic invert_reg, invert_next;
  logic [DIV_W-1:0] debug_div_reg, debug_div_next;
  logic [DIV_W-1:0] trace_div_reg, trace_div_next;
  logic [DIV_W-1:0] fabric_div_reg, fabric_div_next;
  logic [IN_DIV_W-1:0] in_div_reg [NUM_PLL];
  logic [IN_DIV_W-1:0] in_div_next [NUM_PLL];
  logic [FB_DIV_W-1:0] fb_div_reg [NUM_PLL];
  logic [FB_DIV_W-1:0] fb_div_next [NUM_PLL];
  logic [OUT_DIV_W-1:0] out_div_reg [NUM_PLL];
  logic [OUT_DIV_W-1:0] out_div_next [NUM_PLL];
  logic [GEN_W-1:0] gen_req_reg, gen_req_next;
  logic [GEN_W-1:0] gen_act_reg, gen_act_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;

  logic setup, wr, in_pll;
  logic [4:0] pll_slot;
  logic [2:0] pll_idx;
  logic [1:0] big_act, little_act;
  logic big_busy, little_busy;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign in_pll = (paddr >= OFS_PLL_BASE) && (paddr <= OFS_PLL_LAST) &&
                  (paddr[1:0] == 2'h0);
  assign pll_slot = paddr[7:3] - OFS_PLL_BASE[7:3];
  assign pll_idx = pll_slot[2:0];

  function automatic logic [FB_DIV_W-1:0] default_fb(input int idx);
    default_fb = (idx == PLL_MEMORY) ? RST_FB_X8 : RST_FB_X20;
  endfunction : default_fb

  always_comb begin
    big_sel_next = big_sel_reg;
    little_sel_next = little_sel_reg;
    ref_sel_next = ref_sel_reg;
    bypass_next = bypass_reg;
    invert_next = invert_reg;
    debug_div_next = debug_div_reg;
    trace_div_next = trace_div_reg;
    fabric_div_next = fabric_div_reg;
    in_div_next = in_div_reg;
    fb_div_next = fb_div_reg;
    out_div_next = out_div_reg;
    gen_req_next = gen_req_reg;
    gen_act_next = round_to_step(gen_req_reg);
    rdata_next = rdata_reg;
    err_next = err_reg;
    // Read data and error prepared in the setup cycle
    if (setup) begin
      rdata_next = 32'h0;
      err_next = 1'b0;
      if (in_pll) begin
        if (paddr[2]) begin
          rdata_next[FB_DIV_W-1:0] = fb_div_reg[pll_idx];
        end else begin
          rdata_next[IN_DIV_W-1:0] = in_div_reg[pll_idx];
          rdata_next[OUT_DIV_LSB +: OUT_DIV_W] = out_div_reg[pll_idx];
        end
      end else begin
        case (paddr)
          OFS_SELECT: begin
            rdata_next[SEL_BIG_LSB +: 2] = big_sel_reg;
            rdata_next[SEL_LITTLE_LSB +: 2] = little_sel_reg;
            rdata_next[SEL_REF_LSB +: NUM_REFSEL] = ref_sel_reg;
            rdata_next[SEL_BYP_LSB +: NUM_PLL] = bypass_reg;
            rdata_next[SEL_INV_BIT] = invert_reg;
          end
          OFS_STATUS: begin
            rdata_next[STS_BIG_LSB +: 2] = big_act;
            rdata_next[STS_LITTLE_LSB +: 2] = little_act;
            rdata_next[STS_BIG_BUSY] = big_busy;
            rdata_next[STS_LITTLE_BUSY] = little_busy;
          end
          OFS_DIVIDE: begin
            rdata_next[DIV_DEBUG_LSB +: DIV_W] = debug_div_reg;
            rdata_next[DIV_TRACE_LSB +: DIV_W] = trace_div_reg;
            rdata_next[DIV_FABRIC_LSB +: DIV_W] = fabric_div_reg;
          end
          OFS_GEN_REQ: rdata_next[GEN_W-1:0] = gen_req_reg;
          OFS_GEN_ACT: rdata_next[GEN_W-1:0] = gen_act_reg;
          default: err_next = 1'b1;
        endcase
      end
    end
    // Run-time writes at the access edge
    if (wr && !err_reg) begin
      if (in_pll) begin
        if (paddr[2]) begin
          fb_div_next[pll_idx] = pwdata[FB_DIV_W-1:0];
        end else begin
          in_div_next[pll_idx] = pwdata[IN_DIV_W-1:0];
          out_div_next[pll_idx] = pwdata[OUT_DIV_LSB +: OUT_DIV_W];
        end
      end else begin
        case (paddr)
          OFS_SELECT: begin
            big_sel_next = pwdata[SEL_BIG_LSB +: 2];
            little_sel_next = pwdata[SEL_LITTLE_LSB +: 2];
            ref_sel_next = pwdata[SEL_REF_LSB +: NUM_REFSEL];
            bypass_next = pwdata[SEL_BYP_LSB +: NUM_PLL];
            invert_next = pwdata[SEL_INV_BIT];
          end
          OFS_DIVIDE: begin
            debug_div_next = pwdata[DIV_DEBUG_LSB +: DIV_W];
            trace_div_next = pwdata[DIV_TRACE_LSB +: DIV_W];
            fabric_div_next = pwdata[DIV_FABRIC_LSB +: DIV_W];
          end
          OFS_GEN_REQ: gen_req_next = pwdata[GEN_W-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      big_sel_reg <= RST_CLUSTER_SEL;
      little_sel_reg <= RST_CLUSTER_SEL;
      ref_sel_reg <= RST_REF_SEL;
      bypass_reg <= RST_BYPASS;
      invert_reg <= RST_INVERT;
      debug_div_reg <= RST_DEBUG_DIV;
      trace_div_reg <= RST_TRACE_DIV;
      fabric_div_reg <= RST_FABRIC_DIV;
      for (int i = 0; i < NUM_PLL; i++) begin
        in_div_reg[i] <= RST_IN_DIV;
        fb_div_reg[i] <= default_fb(i);
        out_div_reg[i] <= RST_OUT_DIV;
      end
      gen_req_reg <= RST_GEN_REQ;
      gen_act_reg <= RST_GEN_ACT;
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end else begin
      big_sel_reg <= big_sel_next;
      little_sel_reg <= little_sel_next;
      ref_sel_reg <= ref_sel_next;
      bypass_reg <= bypass_next;
      invert_reg <= invert_next;
      debug_div_reg <= debug_div_next;
      trace_div_reg <= trace_div_next;
      fabric_div_reg <= fabric_div_next;
      in_div_reg <= in_div_next;
      fb_div_reg <= fb_div_next;
      out_div_reg <= out_div_next;
      gen_req_reg <= gen_req_next;
      gen_act_reg <= gen_act_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign generator_setting = gen_act_reg;

  // ==========================================================
  // Reference selection, bypass and registered clock levels
  logic [NUM_PLL-1:0] pll_clean, ref_dflt, ref_eff, eff;
  logic [NUM_PLL-1:0] pll_ref_reg, pll_ref_next;
  logic [NUM_PLL-1:0] eff_reg, eff_next;
  logic pix_out_reg, pix_out_next;
  logic sysref;

  assign pll_clean = clean_reg[6:0];
  assign sysref = clean_reg[13];
  assign ref_dflt = {sysref, clean_reg[12:7]};

  always_comb begin
    for (int i = 0; i < NUM_PLL; i++) begin
      ref_eff[i] = ref_dflt[i];
      if (i < NUM_REFSEL && ref_sel_reg[i]) begin
        ref_eff[i] = sysref;
      end
      eff[i] = bypass_reg[i] ? ref_eff[i] : pll_clean[i];
    end
    pll_ref_next = ref_eff;
    eff_next = eff;
    pix_out_next = ref_dflt[PLL_PIXEL] ^ invert_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ref_reg <= '0;
      eff_reg <= '0;
      pix_out_reg <= 1'b0;
    end else begin
      pll_ref_reg <= pll_ref_next;
      eff_reg <= eff_next;
      pix_out_reg <= pix_out_next;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PLL; i++) begin
      pll_cfg[i].bypass = bypass_reg[i];
      pll_cfg[i].ref_sel = (i < NUM_REFSEL) ? ref_sel_reg[i] : 1'b0;
      pll_cfg[i].in_div = in_div_reg[i];
      pll_cfg[i].fb_div = fb_div_reg[i];
      pll_cfg[i].out_div = out_div_reg[i];
    end
  end

  assign pll_reference = pll_ref_reg;
  assign board_pixel_clock_out = pix_out_reg;
  assign pixel_clock = eff_reg[PLL_PIXEL];
  // Kept off the divider path; no fabric timing relation
  assign memory_clock = eff_reg[PLL_MEMORY];

  // ==========================================================
  // Dividers: debug, trace, fabric, big half, little half
  logic [NUM_DIV-1:0] div_src, div_out;
  logic [DIV_W-1:0] div_ratio [NUM_DIV];

  always_comb begin
    div_src = {eff_reg[PLL_LITTLE0], eff_reg[PLL_BIG0],
               {3{eff_reg[PLL_SYSTEM]}}};
    div_ratio[0] = debug_div_reg;
    div_ratio[1] = trace_div_reg;
    div_ratio[2] = fabric_div_reg;
    div_ratio[3] = HALF_DIV;
    div_ratio[4] = HALF_DIV;
  end

  for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
    clk_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .src(div_src[g]),
      .ratio(div_ratio[g]),
      .clk_out(div_out[g])
    );
  end

  assign debug_clock = div_out[0];
  assign trace_port_clock = div_out[1];
  assign fabric_clock = div_out[2];
  assign big_pll0_half = div_out[3];
  assign little_pll0_half = div_out[4];

  // ==========================================================
  // Cluster selectors: 0 PLL0, 1 PLL1, 2 system PLL, 3 PLL0 half
  clk_glitch_mux u_big_mux (
    .pclk(pclk),
    .presetn(presetn),
    .cand({div_out[3], eff_reg[PLL_SYSTEM], eff_reg[PLL_BIG1],
           eff_reg[PLL_BIG0]}),
    .sel(big_sel_reg),
    .clk_out(big_cluster_clock),
    .active_sel(big_act),
    .busy(big_busy)
  );

  clk_glitch_mux u_little_mux (
    .pclk(pclk),
    .presetn(presetn),
    .cand({div_out[4], eff_reg[PLL_SYSTEM], eff_reg[PLL_LITTLE1],
           eff_reg[PLL_LITTLE0]}),
    .sel(little_sel_reg),
    .clk_out(little_cluster_clock),
    .active_sel(little_act),
    .busy(little_busy)
  );

endmodule : clock_source_select

// ==== dv/clk_select_monitor.sv ====
// Port checker for the clock source selection block.
// Assumes it is bound to clock_source_select on pclk.
`timescale 1ns/1ns
module clk_select_monitor
  import clk_select_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  // Clocks and control
  input wire logic pixel_reference_clock,
  input wire logic board_pixel_clock_out,
  input wire logic big_cluster_clock,
  input wire logic little_cluster_clock,
  input wire pll_cfg_s [NUM_PLL-1:0] pll_cfg,
  input wire logic [GEN_W-1:0] generator_setting
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  err_place_a: assert property (pslverr |-> acc)
    else $error("slave error outside access phase");
  unmapped_a: assert property (acc && paddr > OFS_GEN_ACT |-> pslverr)
    else $error("unmapped access without error");
  mapped_a: assert property (acc && paddr == OFS_SELECT |-> !pslverr)
    else $error("error on mapped register");
  gen_hold_a: assert property (!$stable(generator_setting) |->
    $past(acc && pwrite) || $past(acc && pwrite, 2))
    else $error("generator setting moved without a write");
  cfg_hold_a: assert property (!$stable(pll_cfg) |->
    $past(acc && pwrite) || $past(acc && pwrite, 2))
    else $error("pll control moved without a write");
  big_clean_a: assert property ($rose(big_cluster_clock) |=>
    big_cluster_clock [*2])
    else $error("short pulse on big cluster clock");
  little_clean_a: assert property ($rose(little_cluster_clock) |=>
    little_cluster_clock [*2])
    else $error("short pulse on little cluster clock");
  pixel_follow_a: assert property ($rose(pixel_reference_clock) |->
    ##[2:8] !$stable(board_pixel_clock_out))
    else $error("board pixel clock does not follow");
endmodule : clk_select_monitor

bind clock_source_select clk_select_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pslverr(pslverr),
  .pixel_reference_clock(pixel_reference_clock),
  .board_pixel_clock_out(board_pixel_clock_out),
  .big_cluster_clock(big_cluster_clock),
  .little_cluster_clock(little_cluster_clock), .pll_cfg(pll_cfg),
  .generator_setting(generator_setting));

// ==== dv/cfg_ctrl_model.sv ====
// Board configuration controller: APB master on pclk.
// Assumes the slave answers with pready; waits are bounded.
`timescale 1ns/1ns
module cfg_ctrl_model
  import clk_select_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB master
  output logic [ADDR_W-1:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Same cycle for power-up programming and run-time changes
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    hung = (n == 64);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : cfg_ctrl_model

// ==== dv/tb_clock_source_select.sv ====
// Testbench for clock_source_select with a register model.
// Assumes slow clock sources sampled on a 20 MHz pclk.
`timescale 1ns/1ns
module tb_clock_source_select
  import clk_select_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, h;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [GEN_W-1:0] gs;
  logic [31:0] lfsr = 32'hc933;
  logic [7:0] cnt = 8'h00;
  logic [13:0] src;
  int err_total = 0;
  int compares = 0;
  int mdl[int];

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cnt <= cnt + 8'h01;
  // Free-running sources, half periods 8 to 64 cycles
  assign src = {cnt[3], cnt[4], cnt[5], cnt[3], cnt[4], cnt[5], cnt[6],
    cnt[6], cnt[5], cnt[4], cnt[3], cnt[5], cnt[4], cnt[3]};

  cfg_ctrl_model u_cfg (.pclk(pclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  clock_source_select u_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .big_pll0_output(src[0]), .big_pll1_output(src[1]),
    .little_pll0_output(src[2]), .little_pll1_output(src[3]),
    .pixel_pll_output(src[4]), .memory_pll_output(src[5]),
    .system_pll_output(src[6]), .big_pll0_reference(src[7]),
    .big_pll1_reference(src[8]), .little_pll0_reference(src[9]),
    .little_pll1_reference(src[10]), .pixel_reference_clock(src[11]),
    .memory_pll_reference(src[12]), .system_reference_clock(src[13]),
    .pll_cfg(), .pll_reference(), .generator_setting(gs),
    .big_cluster_clock(), .little_cluster_clock(),
    .board_pixel_clock_out(), .pixel_clock(), .memory_clock(),
    .debug_clock(), .trace_port_clock(), .fabric_clock(),
    .big_pll0_half(), .little_pll0_half());

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    u_cfg.xfer(wr, a, d, q, e, h);
    if (h) begin
      err_total++;
      give_verdict();
    end
    if (wr) mdl[a] = d;
  endtask : bus

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), mdl[a], q);
  endtask : rd

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    mdl[OFS_SELECT] = 32'h4000;
    mdl[OFS_STATUS] = 0;
    mdl[OFS_DIVIDE] = 32'h242;
    mdl[OFS_GEN_ACT] = 32'hc340;
    for (int i = 0; i < 7; i++) begin
      mdl[OFS_PLL_BASE + 8 * i] = 0;
      mdl[OFS_PLL_BASE + 8 * i + 4] = (i == 5) ? 7 : 19;
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (mdl[a]) rd(8'(a));
    bus(1'b0, 8'hf0, 32'h0);
    chk("unmapped error", 1, {31'h0, e});
    $display("Test reset and map done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_SELECT, 32'h4000 | i | (i << 2));
      mdl[OFS_STATUS] = i | (i << 2);
      repeat (100) begin
        bus(1'b0, OFS_STATUS, 32'h0);
        if (q[5:4] === 2'b00) break;
      end
      rd(OFS_STATUS);
    end
    $display("Test cluster selection done");
    repeat (4) begin
      lfsr = nxt(lfsr);
      bus(1'b1, OFS_GEN_REQ, {12'h0, lfsr[19:0]});
      v = lfsr[19:0] + 32;
      mdl[OFS_GEN_ACT] = v[20] ? 32'hfffc0 : v & 32'hfffc0;
      rd(OFS_GEN_ACT);
      chk("generator", mdl[OFS_GEN_ACT], {12'h0, gs});
      bus(1'b1, OFS_DIVIDE, {20'h0, lfsr[31:20]});
      rd(OFS_DIVIDE);
      bus(1'b1, OFS_PLL_BASE + 8'h0c, {19'h0, lfsr[12:0]});
      rd(OFS_PLL_BASE + 8'h0c);
      bus(1'b1, OFS_SELECT, {lfsr[17], 7'h10, lfsr[9:4], 4'hf});
      rd(OFS_SELECT);
    end
    $display("Test random settings done");
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
endmodule : tb_clock_source_select
